// ==== hdl/alarm_defines.vh ====
// Register offsets, field positions, reset values and codes of the alarm repeat unit.
`ifndef ALARM_DEFINES_VH
`define ALARM_DEFINES_VH

`define OFS_ALARM_CONFIG_REPEAT 12'h000
`define OFS_ALARM_TIME_LO       12'h004
`define OFS_ALARM_TIME_HI       12'h008
`define OFS_IRQ_STATUS          12'h00C
`define OFS_IRQ_CLEAR           12'h010
`define OFS_IRQ_ENABLE          12'h014
`define OFS_UNIT_STATUS         12'h018

`define BIT_ALARM_ENABLE   15
`define BIT_REPEAT_FOREVER 14
`define MASK_MSB           13
`define MASK_LSB           10
`define RPT_MSB            7
`define RPT_LSB            0

`define CFG_RESET       16'h0000
`define RPT_ZERO        8'h00
`define RPT_FULL        8'hFF

`define MASK_HALF_SEC   4'h0
`define MASK_SECOND     4'h1
`define MASK_TEN_SEC    4'h2
`define MASK_MINUTE     4'h3
`define MASK_TEN_MIN    4'h4
`define MASK_HOUR       4'h5
`define MASK_DAY        4'h6
`define MASK_WEEK       4'h7
`define MASK_MONTH      4'h8
`define MASK_YEAR       4'h9

`define IRQ_ALARM       0
`define IRQ_FINAL       1
`define IRQ_WIDTH       2

`endif

// ==== hdl/alarm_digit_compare.v ====
// Masked comparison of the running time digits against the alarm time.
`timescale 1ns/100ps
`include "alarm_defines.vh"

module alarm_digit_compare (
    input  wire        pclk,
    input  wire        presetn,
    input  wire [3:0]  mask,
    input  wire [6:0]  now_sec,
    input  wire [6:0]  now_min,
    input  wire [5:0]  now_hour,
    input  wire [2:0]  now_wday,
    input  wire [5:0]  now_day,
    input  wire [4:0]  now_month,
    input  wire [6:0]  alm_sec,
    input  wire [6:0]  alm_min,
    input  wire [5:0]  alm_hour,
    input  wire [2:0]  alm_wday,
    input  wire [5:0]  alm_day,
    input  wire [4:0]  alm_month,
    output reg         match_q
);

    reg match_d;

    // From the ten-second mask up, the wider the interval, the more digits must agree; the half-second and second masks compare none.
    always @* begin
        case (mask)
            `MASK_HALF_SEC: match_d = 1'b1;
            `MASK_SECOND:   match_d = 1'b1;
            `MASK_TEN_SEC:  match_d = now_sec[3:0] == alm_sec[3:0];
            `MASK_MINUTE:   match_d = now_sec == alm_sec;
            `MASK_TEN_MIN:  match_d = now_sec == alm_sec && now_min[3:0] == alm_min[3:0];
            `MASK_HOUR:     match_d = now_sec == alm_sec && now_min == alm_min;
            `MASK_DAY:      match_d = now_sec == alm_sec && now_min == alm_min
                                      && now_hour == alm_hour;
            `MASK_WEEK:     match_d = now_sec == alm_sec && now_min == alm_min
                                      && now_hour == alm_hour && now_wday == alm_wday;
            `MASK_MONTH:    match_d = now_sec == alm_sec && now_min == alm_min
                                      && now_hour == alm_hour && now_day == alm_day;
            `MASK_YEAR:     match_d = now_sec == alm_sec && now_min == alm_min
                                      && now_hour == alm_hour && now_day == alm_day
                                      && now_month == alm_month;
            default:        match_d = 1'b0;
        endcase
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            match_q <= 1'b0;
        end else begin
            match_q <= match_d;
        end
    end

endmodule // alarm_digit_compare

// ==== hdl/clock_alarm_repeat_unit.v ====
// Alarm repeat unit of the calendar clock with its APB register port.
//
// The APB interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/100ps
`include "alarm_defines.vh"

module clock_alarm_repeat_unit (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire        half_sec_tick,
    input  wire        rollover_sync_flag,
    input  wire [6:0]  now_sec,
    input  wire [6:0]  now_min,
    input  wire [5:0]  now_hour,
    input  wire [2:0]  now_wday,
    input  wire [5:0]  now_day,
    input  wire [4:0]  now_month,
    output reg         alarm_pulse_q,
    output reg         alarm_irq_q
);

    localparam ST_IDLE  = 3'b001;
    localparam ST_EVAL  = 3'b010;
    localparam ST_FIRE  = 3'b100;

    reg  [15:0] cfg_q;
    reg  [31:0] time_lo_q;
    reg  [31:0] time_hi_q;
    reg  [`IRQ_WIDTH-1:0] irq_stat_q;
    reg  [`IRQ_WIDTH-1:0] irq_en_q;
    reg  [2:0]  state_q;
    reg  [2:0]  state_d;
    reg         sec_phase_q;
    reg         alarm_event;
    wire        match;
    wire        setup;
    wire        wr_acc;
    wire        rd_acc;
    wire        cfg_wr;
    wire        addr_ok;
    wire [3:0]  mask;
    wire [7:0]  rpt;
    wire        last_alarm;
    wire [`IRQ_WIDTH-1:0] irq_set;
    wire [`IRQ_WIDTH-1:0] irq_clr;

    assign setup  = psel && !penable;
    assign wr_acc = psel && penable && pready && pwrite;
    assign rd_acc = setup && !pwrite;
    assign addr_ok = paddr == `OFS_ALARM_CONFIG_REPEAT || paddr == `OFS_ALARM_TIME_LO
                     || paddr == `OFS_ALARM_TIME_HI || paddr == `OFS_IRQ_STATUS
                     || paddr == `OFS_IRQ_CLEAR || paddr == `OFS_IRQ_ENABLE
                     || paddr == `OFS_UNIT_STATUS;
    assign cfg_wr = wr_acc && paddr == `OFS_ALARM_CONFIG_REPEAT;
    assign mask   = cfg_q[`MASK_MSB:`MASK_LSB];
    assign rpt    = cfg_q[`RPT_MSB:`RPT_LSB];
    assign last_alarm = rpt == `RPT_ZERO && !cfg_q[`BIT_REPEAT_FOREVER];

    // Time register fields: lo = sec[6:0], min[14:8], hour[21:16], wday[26:24].
    // hi = day[5:0], month[12:8].
    alarm_digit_compare u_cmp (
        .pclk      (pclk),
        .presetn   (presetn),
        .mask      (mask),
        .now_sec   (now_sec),
        .now_min   (now_min),
        .now_hour  (now_hour),
        .now_wday  (now_wday),
        .now_day   (now_day),
        .now_month (now_month),
        .alm_sec   (time_lo_q[6:0]),
        .alm_min   (time_lo_q[14:8]),
        .alm_hour  (time_lo_q[21:16]),
        .alm_wday  (time_lo_q[26:24]),
        .alm_day   (time_hi_q[5:0]),
        .alm_month (time_hi_q[12:8]),
        .match_q   (match)
    );

    // The compare result is registered, so a tick is first latched and then judged one
    // cycle later against stable digits; config writes never touch the digits themselves.
    always @* begin
        state_d     = state_q;
        alarm_event = 1'b0;
        case (state_q)
            ST_IDLE: begin
                if (half_sec_tick && cfg_q[`BIT_ALARM_ENABLE]) begin
                    state_d = ST_EVAL;
                end
            end
            ST_EVAL: begin
                // The half-second mask fires every tick, the second mask only on whole seconds.
                if (match && cfg_q[`BIT_ALARM_ENABLE]
                    && (mask != `MASK_SECOND || sec_phase_q)) begin
                    state_d = ST_FIRE;
                end else begin
                    state_d = ST_IDLE;
                end
            end
            ST_FIRE: begin
                alarm_event = 1'b1;
                state_d     = ST_IDLE;
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    assign irq_set = {alarm_event && last_alarm, alarm_event};
    assign irq_clr = (wr_acc && paddr == `OFS_IRQ_CLEAR) ? pwdata[`IRQ_WIDTH-1:0]
                                                         : {`IRQ_WIDTH{1'b0}};

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q       <= ST_IDLE;
            sec_phase_q   <= 1'b0;
            cfg_q         <= `CFG_RESET;
            time_lo_q     <= 32'h00000000;
            time_hi_q     <= 32'h00000000;
            irq_stat_q    <= {`IRQ_WIDTH{1'b0}};
            irq_en_q      <= {`IRQ_WIDTH{1'b0}};
            alarm_pulse_q <= 1'b0;
            alarm_irq_q   <= 1'b0;
        end else begin
            state_q <= state_d;
            if (half_sec_tick) begin
                sec_phase_q <= ~sec_phase_q;
            end
            if (cfg_wr) begin
                cfg_q <= {pwdata[15:14], pwdata[13:10], 2'b00, pwdata[7:0]};
            end else if (alarm_event) begin
                if (last_alarm) begin
                    cfg_q[`BIT_ALARM_ENABLE] <= 1'b0;
                end else begin
                    // Zero wraps to FFh only when repeat_forever is set.
                    cfg_q[`RPT_MSB:`RPT_LSB] <= rpt - 8'h01;
                end
            end
            if (wr_acc && paddr == `OFS_ALARM_TIME_LO) begin
                time_lo_q <= pwdata & 32'h073F7F7F;
            end
            if (wr_acc && paddr == `OFS_ALARM_TIME_HI) begin
                time_hi_q <= pwdata & 32'h00001F3F;
            end
            if (wr_acc && paddr == `OFS_IRQ_ENABLE) begin
                irq_en_q <= pwdata[`IRQ_WIDTH-1:0];
            end
            // Set wins over a clear in the same cycle.
            irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_set;
            alarm_irq_q <= |(((irq_stat_q & ~irq_clr) | irq_set) & irq_en_q);
            if (alarm_event) begin
                alarm_pulse_q <= ~alarm_pulse_q;
            end
        end
    end

    // Zero-wait APB slave: ready in every access phase, read data captured in setup.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h00000000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= setup;
            pslverr <= setup && !addr_ok;
            if (rd_acc) begin
                case (paddr)
                    `OFS_ALARM_CONFIG_REPEAT: prdata <= {16'h0000, cfg_q};
                    `OFS_ALARM_TIME_LO:       prdata <= time_lo_q;
                    `OFS_ALARM_TIME_HI:       prdata <= time_hi_q;
                    `OFS_IRQ_STATUS:          prdata <= {30'h00000000, irq_stat_q};
                    `OFS_IRQ_ENABLE:          prdata <= {30'h00000000, irq_en_q};
                    `OFS_UNIT_STATUS:         prdata <= {29'h00000000, rollover_sync_flag,
                                                         alarm_pulse_q, match};
                    default:                  prdata <= 32'h00000000;
                endcase
            end else if (setup) begin
                prdata <= 32'h00000000;
            end
        end
    end

endmodule // clock_alarm_repeat_unit

// ==== tb/alarm_unit_asserts.sv ====
// Port checker for the alarm repeat unit, bound to its top module.
`timescale 1ns/100ps
module alarm_unit_checker (
    input wire        pclk,
    input wire        presetn,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire        pready,
    input wire        pslverr,
    input wire        half_sec_tick,
    input wire        alarm_pulse_q,
    input wire        alarm_irq_q
);
    reg  [2:0] off_age_q;
    wire       apb_wr = psel && pwrite;
    wire       cfg_wr = psel && penable && pready && pwrite && paddr == 12'h000;
    // The age saturates at seven so an alarm still in flight at the disable write is tolerated.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn)
            off_age_q <= 3'h7;
        else if (cfg_wr)
            off_age_q <= {2'h0, !pwdata[15]};
        else if (off_age_q != 3'h0 && off_age_q != 3'h7)
            off_age_q <= off_age_q + 3'h1;
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_recent_tick;
        $past(half_sec_tick, 2) || $past(half_sec_tick, 3) || $past(half_sec_tick, 4);
    endsequence
    sequence s_recent_write;
        $past(apb_wr, 1) || $past(apb_wr, 2) || $past(apb_wr, 3);
    endsequence
    a_pulse_after_tick: assert property (
        $changed(alarm_pulse_q) |-> s_recent_tick) else $error("pulse moved without a tick");
    a_pulse_toggle_once: assert property (
        $changed(alarm_pulse_q) |=> $stable(alarm_pulse_q)[*3]) else $error("pulse moved twice");
    a_no_alarm_off: assert property (
        off_age_q == 3'h7 |-> $stable(alarm_pulse_q)) else $error("alarm while disabled");
    a_irq_from_event: assert property (
        $rose(alarm_irq_q) |-> ($changed(alarm_pulse_q) or s_recent_write))
        else $error("interrupt without alarm event");
    a_ready_next_cycle: assert property (
        psel && !penable |=> pready) else $error("ready late");
    a_ready_in_access: assert property (
        pready |-> psel && penable) else $error("ready outside access");
    a_err_unmapped: assert property (
        pready && paddr > 12'h018 |-> pslverr) else $error("no error for unmapped address");
    a_err_mapped: assert property (
        pready && paddr <= 12'h018 && paddr[1:0] == 2'h0 |-> !pslverr) else $error("bad error");
endmodule // alarm_unit_checker
bind clock_alarm_repeat_unit alarm_unit_checker chk_u (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .pslverr(pslverr), .half_sec_tick(half_sec_tick),
    .alarm_pulse_q(alarm_pulse_q), .alarm_irq_q(alarm_irq_q));

// ==== tb/clock_alarm_repeat_unit_test.sv ====
// Self-checking bench of the alarm repeat unit against a behavioural model.
`timescale 1ns/100ps
`include "alarm_defines.vh"
module clock_alarm_repeat_unit_test;
    reg         pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    reg  [11:0] paddr = 12'h000;
    reg  [31:0] pwdata = 32'h0;
    reg         half_sec_tick = 1'b0;
    reg         rollover_sync_flag = 1'b0;
    reg  [6:0]  now_sec = 7'h00, now_min = 7'h00;
    reg  [5:0]  now_hour = 6'h00, now_day = 6'h00;
    reg  [4:0]  now_month = 5'h00;
    reg  [2:0]  now_wday = 3'h0;
    wire [31:0] prdata;
    wire        pready, pslverr, alarm_pulse_q, alarm_irq_q;
    logic [31:0] rd;
    logic        er;
    integer mismatches = 0, total_checks = 0, cycles = 0, seed = 23;
    integer en = 0, fv = 0, mk = 0, cnt = 0, pul = 0, st = 0, ie = 0, sec_ok = 1, m;
    // Ticks seen since reset; the whole-second mask fires on every odd one.
    integer ntick = 0;
    clock_alarm_repeat_unit dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .half_sec_tick(half_sec_tick),
        .rollover_sync_flag(rollover_sync_flag), .now_sec(now_sec), .now_min(now_min),
        .now_hour(now_hour), .now_wday(now_wday), .now_day(now_day), .now_month(now_month),
        .alarm_pulse_q(alarm_pulse_q), .alarm_irq_q(alarm_irq_q));
    always #20 pclk = ~pclk;
    always @(posedge pclk) begin
        cycles = cycles + 1;
        if (cycles == 20000) begin
            mismatches = mismatches + 1;
            end_of_test;
        end
    end
    task end_of_test;
        if (mismatches == 0 && total_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks = total_checks + 1;
        if (seen !== exp) begin
            mismatches = mismatches + 1;
            $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    // The request is held until pready is seen high at a rising edge.
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task rc(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rd, e);
    endtask
    task wc(input integer e, input integer f, input integer k, input integer c);
        en = e;
        fv = f;
        mk = k;
        cnt = c;
        apb(1'b1, `OFS_ALARM_CONFIG_REPEAT, e * 32768 + f * 16384 + k * 1024 + c);
    endtask
    task clr;
        apb(1'b1, `OFS_IRQ_CLEAR, 32'h3);
        st = 0;
    endtask
    task tick;
        ntick = ntick + 1;
        @(posedge pclk);
        half_sec_tick <= 1'b1;
        @(posedge pclk);
        half_sec_tick <= 1'b0;
        repeat (5) @(posedge pclk);
        if (en && (mk == 0 || (mk == 1 && ntick % 2 == 1)
                   || (mk > 1 && mk <= 9 && sec_ok))) begin
            pul = !pul;
            st = st | 1;
            if (cnt == 0 && !fv) begin
                en = 0;
                st = st | 2;
            end else
                cnt = (cnt + 255) % 256;
        end
        chk(alarm_pulse_q, pul);
        chk(alarm_irq_q, (st & ie) != 0);
        rc(`OFS_ALARM_CONFIG_REPEAT, en * 32768 + fv * 16384 + mk * 1024 + cnt);
        rc(`OFS_IRQ_STATUS, st);
    endtask
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        rc(`OFS_ALARM_CONFIG_REPEAT, `CFG_RESET);
        rc(`OFS_IRQ_CLEAR, 32'h0);
        rc(12'h01C, 32'h0);
        chk(er, 1'b1);
        rollover_sync_flag <= 1'b1;
        rc(`OFS_UNIT_STATUS, 32'h5);
        rollover_sync_flag <= 1'b0;
        now_sec <= $random(seed);
        now_min <= $random(seed);
        now_hour <= $random(seed);
        now_wday <= $random(seed);
        now_day <= $random(seed);
        now_month <= $random(seed);
        @(posedge pclk);
        apb(1'b1, `OFS_ALARM_TIME_LO, {5'h00, now_wday, 2'h0, now_hour, 1'b0, now_min, 1'b0,
            now_sec});
        apb(1'b1, `OFS_ALARM_TIME_HI, {19'h0, now_month, 2'h0, now_day});
        ie = 3;
        apb(1'b1, `OFS_IRQ_ENABLE, 32'h3);
        for (m = 0; m < 16; m = m + 1) begin
            wc(1, 0, m, 0);
            tick;
            wc(0, 0, m, 0);
            clr;
        end
        wc(1, 0, `MASK_SECOND, 1);
        repeat (4) tick;
        wc(1, 0, `MASK_MINUTE, 2);
        repeat (4) tick;
        wc(1, 1, `MASK_MINUTE, 1);
        repeat (3) tick;
        wc(1, 0, `MASK_MINUTE, 5);
        wc(1, 0, `MASK_MINUTE, 7);
        repeat (8) @(posedge pclk);
        chk(alarm_pulse_q, pul);
        tick;
        now_min <= $random(seed);
        wc(1, 0, `MASK_MINUTE, 0);
        tick;
        now_sec <= now_sec ^ 7'h01;
        sec_ok = 0;
        wc(1, 0, `MASK_SECOND + 1, 0);
        tick;
        wc(0, 0, 0, 0);
        ie = 0;
        apb(1'b1, `OFS_IRQ_ENABLE, 32'h0);
        clr;
        wc(1, 0, `MASK_HALF_SEC, 0);
        tick;
        clr;
        ie = 3;
        apb(1'b1, `OFS_IRQ_ENABLE, 32'h3);
        wc(1, 0, `MASK_HALF_SEC, 255);
        repeat (257) tick;
        end_of_test;
    end
endmodule // clock_alarm_repeat_unit_test
